// [ethernet_interrupt_flags.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - packet pending flag, bit 6, high while an unprocessed packet waits
// - decrement of the last packet drops pending; flag low while the buffer is empty
// - copy done flag, bit 5, set when a copy or checksum finishes
// - link change flag, bit 4, set when the phy reports a link change
// - link change flag cleared only by reading the phy flag register
// - transmit done flag, bit 3, set when a requested transmission ends
// - transmit error flag, bit 1, set on a transmit error
// - packet aborted and receive error bit 0 set if full or count 255
// - receive error flag stays set until host clear or reset
// - receive error with its enable and global enable drives irq pin low
module ethernet_interrupt_flags
(
   input  wire logic                    ref_clk,
   input  wire logic                    rstn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire irq_flags_pkg::events_s  events,
   input  wire logic                    buffer_no_space,
   output logic                         packet_abort,
   output logic                         irq_n
);

   logic [7:0]  flags_q;
   logic [7:0]  enables_q;
   logic [7:0]  pkt_count;
   logic        pkt_at_max;
   logic        phy_link_q;
   logic        wr_en;
   logic        rd_en;
   logic        packet_decrement;
   logic        phy_read;
   logic        clear_wr;
   logic        accept;
   logic [7:0]  view;
   logic [31:0] prdata_d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign pslverr = psel && penable &&
                    !(hit(paddr, irq_flags_pkg::OFS_FLAGS)
                      || hit(paddr, irq_flags_pkg::OFS_ENABLES)
                      || hit(paddr, irq_flags_pkg::OFS_CLEAR)
                      || hit(paddr, irq_flags_pkg::OFS_PHY_FLAGS)
                      || hit(paddr, irq_flags_pkg::OFS_CONTROL)
                      || hit(paddr, irq_flags_pkg::OFS_PKT_COUNT));
   assign packet_decrement = wr_en && hit(paddr, irq_flags_pkg::OFS_CONTROL)
                             && pwdata[irq_flags_pkg::BIT_PKT_DEC];
   assign phy_read = rd_en && hit(paddr, irq_flags_pkg::OFS_PHY_FLAGS);
   assign clear_wr = wr_en && hit(paddr, irq_flags_pkg::OFS_CLEAR);

   // packet lost at start if no room or the count cannot grow
   assign packet_abort = events.rx_start_full
                         && (buffer_no_space || pkt_at_max);
   assign accept = events.rx_start_full && !packet_abort;

   pkt_counter #(.WIDTH(8)) u_count
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .inc     (accept),
      .dec     (packet_decrement),
      .count_q (pkt_count),
      .at_max  (pkt_at_max)
   );

   // sticky flags: a set in the clear cycle wins
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         flags_q <= irq_flags_pkg::FLAGS_RESET;
      else
      begin
         if (clear_wr)
         begin
            flags_q[irq_flags_pkg::BIT_COPY] <=
               flags_q[irq_flags_pkg::BIT_COPY] &
               ~(pwdata[irq_flags_pkg::BIT_COPY]
                 & irq_flags_pkg::CLEARABLE[irq_flags_pkg::BIT_COPY]);
            flags_q[irq_flags_pkg::BIT_TX_DONE] <=
               flags_q[irq_flags_pkg::BIT_TX_DONE] &
               ~pwdata[irq_flags_pkg::BIT_TX_DONE];
            flags_q[irq_flags_pkg::BIT_TX_ERR] <=
               flags_q[irq_flags_pkg::BIT_TX_ERR] &
               ~pwdata[irq_flags_pkg::BIT_TX_ERR];
            flags_q[irq_flags_pkg::BIT_RX_ERR] <=
               flags_q[irq_flags_pkg::BIT_RX_ERR] &
               ~pwdata[irq_flags_pkg::BIT_RX_ERR];
         end
         if (events.copy_done)
            flags_q[irq_flags_pkg::BIT_COPY] <= 1'b1;
         if (events.tx_done)
            flags_q[irq_flags_pkg::BIT_TX_DONE] <= 1'b1;
         if (events.tx_error)
            flags_q[irq_flags_pkg::BIT_TX_ERR] <= 1'b1;
         if (packet_abort)
            flags_q[irq_flags_pkg::BIT_RX_ERR] <= 1'b1;
         // link flag ignores clear writes; only the phy read drops it
         if (events.link_change)
            flags_q[irq_flags_pkg::BIT_LINK] <= 1'b1;
         else if (phy_read)
            flags_q[irq_flags_pkg::BIT_LINK] <= 1'b0;
         flags_q[irq_flags_pkg::BIT_RSVD]  <= 1'b0;
         flags_q[irq_flags_pkg::BIT_UNIMP] <= 1'b0;
         flags_q[irq_flags_pkg::BIT_PKT]   <= 1'b0;
      end
   end

   // pending flag follows the count directly, never stored
   always_comb
   begin
      view = flags_q;
      view[irq_flags_pkg::BIT_PKT] = (pkt_count != 8'h00);
   end

   // phy flag register mirror of the link flag, self clearing on read
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         phy_link_q <= 1'b0;
      else if (events.link_change)
         phy_link_q <= 1'b1;
      else if (phy_read)
         phy_link_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         enables_q <= irq_flags_pkg::ENABLES_RESET;
      else if (wr_en && hit(paddr, irq_flags_pkg::OFS_ENABLES))
         enables_q <= pwdata[7:0] & 8'hfb;
   end

   always_comb
   begin
      prdata_d = 32'h0000_0000;
      if (hit(paddr, irq_flags_pkg::OFS_FLAGS))
         prdata_d = {24'h00_0000, view};
      else if (hit(paddr, irq_flags_pkg::OFS_ENABLES))
         prdata_d = {24'h00_0000, enables_q};
      else if (hit(paddr, irq_flags_pkg::OFS_PHY_FLAGS))
         prdata_d = {27'h000_0000, phy_link_q, 4'h0};
      else if (hit(paddr, irq_flags_pkg::OFS_PKT_COUNT))
         prdata_d = {24'h00_0000, pkt_count};
   end

   // read data registered in the setup cycle, valid at the access edge
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= prdata_d;
   end

   // pin is active low; global enable gates every source
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         irq_n <= 1'b1;
      else
         irq_n <= !(enables_q[irq_flags_pkg::BIT_GLOBAL_EN]
                    && |(view & enables_q & 8'h7b));
   end

   property p_rx_err_set;
      @(posedge ref_clk) disable iff (!rstn)
      packet_abort |=> flags_q[irq_flags_pkg::BIT_RX_ERR];
   endproperty
   a_rx_err_set: assert property (p_rx_err_set)
      else $error("receive error not set after abort");

   property p_rx_err_sticky;
      @(posedge ref_clk) disable iff (!rstn)
      flags_q[irq_flags_pkg::BIT_RX_ERR] && !clear_wr
      |=> flags_q[irq_flags_pkg::BIT_RX_ERR];
   endproperty
   a_rx_err_sticky: assert property (p_rx_err_sticky)
      else $error("receive error dropped without host clear");

   property p_abort_cond;
      @(posedge ref_clk) disable iff (!rstn)
      events.rx_start_full && pkt_count == 8'hff |-> packet_abort;
   endproperty
   a_abort_cond: assert property (p_abort_cond)
      else $error("packet at full count not aborted");

   property p_pending;
      @(posedge ref_clk) disable iff (!rstn)
      accept |=> view[irq_flags_pkg::BIT_PKT];
   endproperty
   a_pending: assert property (p_pending)
      else $error("pending flag not raised by a stored packet");

   property p_dec;
      @(posedge ref_clk) disable iff (!rstn)
      packet_decrement && pkt_count == 8'h01 && !events.rx_start_full
      |=> !view[irq_flags_pkg::BIT_PKT];
   endproperty
   a_dec: assert property (p_dec)
      else $error("pending flag kept after last decrement");

   property p_copy;
      @(posedge ref_clk) disable iff (!rstn)
      events.copy_done |=> flags_q[irq_flags_pkg::BIT_COPY];
   endproperty
   a_copy: assert property (p_copy)
      else $error("copy done flag not set");

   property p_link;
      @(posedge ref_clk) disable iff (!rstn)
      flags_q[irq_flags_pkg::BIT_LINK] && !phy_read
      |=> flags_q[irq_flags_pkg::BIT_LINK];
   endproperty
   a_link: assert property (p_link)
      else $error("link flag cleared without phy read");

   property p_link_set;
      @(posedge ref_clk) disable iff (!rstn)
      events.link_change |=> flags_q[irq_flags_pkg::BIT_LINK];
   endproperty
   a_link_set: assert property (p_link_set)
      else $error("link flag not set");

   property p_tx;
      @(posedge ref_clk) disable iff (!rstn)
      events.tx_done |=> flags_q[irq_flags_pkg::BIT_TX_DONE];
   endproperty
   a_tx: assert property (p_tx)
      else $error("transmit done flag not set");

   property p_tx_err;
      @(posedge ref_clk) disable iff (!rstn)
      events.tx_error |=> flags_q[irq_flags_pkg::BIT_TX_ERR];
   endproperty
   a_tx_err: assert property (p_tx_err)
      else $error("transmit error flag not set");

   property p_irq;
      @(posedge ref_clk) disable iff (!rstn)
      enables_q[irq_flags_pkg::BIT_GLOBAL_EN]
      && enables_q[irq_flags_pkg::BIT_RX_ERR]
      && flags_q[irq_flags_pkg::BIT_RX_ERR] |=> !irq_n;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq pin not low on enabled receive error");

   property p_bit7;
      @(posedge ref_clk) disable iff (!rstn)
      !view[irq_flags_pkg::BIT_UNIMP] && !view[irq_flags_pkg::BIT_RSVD];
   endproperty
   a_bit7: assert property (p_bit7)
      else $error("unimplemented flag bit set");

   // an aborted packet must leave the stored count untouched
   property p_count_hold;
      @(posedge ref_clk) disable iff (!rstn)
      packet_abort && !packet_decrement |=> $stable(pkt_count);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("packet count moved on an aborted packet");

   property p_abort_space;
      @(posedge ref_clk) disable iff (!rstn)
      events.rx_start_full && buffer_no_space |-> packet_abort;
   endproperty
   a_abort_space: assert property (p_abort_space)
      else $error("packet without buffer space not aborted");

   property p_clear_effect;
      @(posedge ref_clk) disable iff (!rstn)
      clear_wr && pwdata[irq_flags_pkg::BIT_TX_DONE] && !events.tx_done
      |=> !flags_q[irq_flags_pkg::BIT_TX_DONE];
   endproperty
   a_clear_effect: assert property (p_clear_effect)
      else $error("transmit done flag not cleared by host clear");

   // with the global enable off the pin must stay released
   property p_irq_off;
      @(posedge ref_clk) disable iff (!rstn)
      !enables_q[irq_flags_pkg::BIT_GLOBAL_EN] |=> irq_n;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq pin low with global enable off");

   c_abort: cover property (@(posedge ref_clk) disable iff (!rstn)
      packet_abort);
   c_irq: cover property (@(posedge ref_clk) disable iff (!rstn)
      $fell(irq_n));
   c_clear: cover property (@(posedge ref_clk) disable iff (!rstn)
      clear_wr && flags_q[0]);
   c_link_clear: cover property (@(posedge ref_clk) disable iff (!rstn)
      phy_read && flags_q[irq_flags_pkg::BIT_LINK]);
   c_full: cover property (@(posedge ref_clk) disable iff (!rstn)
      pkt_at_max);

endmodule // ethernet_interrupt_flags

// [irq_flags_pkg.sv]
package irq_flags_pkg;

   // flag bit positions
   localparam int unsigned BIT_RX_ERR   = 0;
   localparam int unsigned BIT_TX_ERR   = 1;
   localparam int unsigned BIT_RSVD     = 2;
   localparam int unsigned BIT_TX_DONE  = 3;
   localparam int unsigned BIT_LINK     = 4;
   localparam int unsigned BIT_COPY     = 5;
   localparam int unsigned BIT_PKT      = 6;
   localparam int unsigned BIT_UNIMP    = 7;

   // apb byte offsets
   localparam logic [7:0] OFS_FLAGS     = 8'h00;
   localparam logic [7:0] OFS_ENABLES   = 8'h04;
   localparam logic [7:0] OFS_CLEAR     = 8'h08;
   localparam logic [7:0] OFS_PHY_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_CONTROL   = 8'h10;
   localparam logic [7:0] OFS_PKT_COUNT = 8'h14;

   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   // flags that host clear operations may reset
   localparam logic [7:0] CLEARABLE     = 8'h2b;
   // bit of the enable register that gates the pin as a whole
   localparam int unsigned BIT_GLOBAL_EN = 7;
   // control register: packet decrement strobe
   localparam int unsigned BIT_PKT_DEC   = 0;
   localparam int unsigned PKT_MAX       = 255;

   typedef struct packed {
      logic copy_done;
      logic link_change;
      logic tx_done;
      logic tx_error;
      logic rx_start_full;
   } events_s;

endpackage

// [pkt_counter.sv]
`timescale 1ns/1ns
module pkt_counter
#(
   parameter int unsigned WIDTH = 8
)
(
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             inc,
   input  wire logic             dec,
   output logic [WIDTH-1:0]      count_q,
   output logic                  at_max
);

   // refused at elaboration: a narrower counter could never reach the cap
   if (WIDTH < 8)
   begin : g_width_check
      $error("pkt_counter: width must hold the maximum count");
   end

   localparam logic [WIDTH-1:0] MAXV = WIDTH'(irq_flags_pkg::PKT_MAX);

   assign at_max = (count_q == MAXV);

   // increment refused at max, decrement refused at zero
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         count_q <= '0;
      else if (inc && !at_max && !(dec && count_q != '0))
         count_q <= count_q + WIDTH'(1);
      else if (dec && count_q != '0 && !(inc && !at_max))
         count_q <= count_q - WIDTH'(1);
   end

endmodule // pkt_counter

// [host_model.sv]
`timescale 1ns/1ns
module host_model
(
   input  wire logic        ref_clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // leading edge wait keeps back to back calls from double driving psel
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask

   task automatic clear_flags(input logic [31:0] m);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, irq_flags_pkg::OFS_CLEAR, m, r, e);
   endtask
endmodule // host_model

// [ethernet_interrupt_flags_tb.sv]
`timescale 1ns/1ns
module ethernet_interrupt_flags_tb;
   logic                   ref_clk;
   logic                   rstn;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   irq_flags_pkg::events_s events;
   logic                   buffer_no_space;
   logic                   packet_abort;
   logic                   irq_n;
   logic [31:0]            rd;
   logic [31:0]            ex;
   logic                   er;
   logic [7:0]             fb [4];
   int                     bad_count;
   int                     tests_run;
   int                     cycles;
   int                     seed;
   int                     n;

   ethernet_interrupt_flags ethernet_interrupt_flags_i (.ref_clk(ref_clk),
      .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .events(events),
      .buffer_no_space(buffer_no_space), .packet_abort(packet_abort),
      .irq_n(irq_n));

   host_model host_model_i (.ref_clk(ref_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // enable register: bit 2 is reserved and never stores
   function automatic logic [31:0] en_exp(input logic [31:0] v);
      return v & 32'hfb;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host_model_i.xfer(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_model_i.xfer(1'b1, a, d, rd, er);
   endtask

   task automatic pulse(input irq_flags_pkg::events_s e);
      @(posedge ref_clk);
      events <= e;
      @(posedge ref_clk);
      events <= '0;
   endtask

   // abort is combinational, so it is looked at mid cycle
   task automatic abort(input logic ns);
      @(posedge ref_clk);
      events <= 5'h01;
      buffer_no_space <= ns;
      #10 chk(32'(packet_abort), 32'h1);
      @(posedge ref_clk);
      events <= '0;
      buffer_no_space <= 1'b0;
   endtask

   task automatic results();
      $display("mismatches %0d, checks %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         bad_count++;
         results();
      end
   end

   initial
   begin
      seed = 36;
      bad_count = 0;
      tests_run = 0;
      cycles = 0;
      fb = '{8'h02, 8'h08, 8'h10, 8'h20};
      rstn = 1'b0;
      events = '0;
      buffer_no_space = 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h0);
      rd_chk(irq_flags_pkg::OFS_ENABLES, 32'h0);
      host_model_i.xfer(1'b0, 8'h18, 32'h0, rd, er);
      chk(32'(er), 32'h1);
      n = $random(seed);
      wr(irq_flags_pkg::OFS_ENABLES, 32'(n));
      rd_chk(irq_flags_pkg::OFS_ENABLES, en_exp(32'(n)));
      ex = 32'h0;
      for (int k = 0; k < 4; k++)
      begin
         pulse(5'(2 << k));
         ex = ex | 32'(fb[k]);
         rd_chk(irq_flags_pkg::OFS_FLAGS, ex);
      end
      wr(irq_flags_pkg::OFS_FLAGS, 32'h0);
      rd_chk(irq_flags_pkg::OFS_FLAGS, ex);
      // clear write and transmit error land on one edge: the set must win
      fork
         host_model_i.clear_flags(32'h02);
         begin
            @(posedge ref_clk);
            pulse(5'h02);
         end
      join
      rd_chk(irq_flags_pkg::OFS_FLAGS, ex);
      host_model_i.clear_flags(32'hff);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h10);
      rd_chk(irq_flags_pkg::OFS_PHY_FLAGS, 32'h10);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h0);
      n = 1 + ($random(seed) & 3);
      repeat (n) pulse(5'h01);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h40);
      rd_chk(irq_flags_pkg::OFS_PKT_COUNT, 32'(n));
      repeat (n) wr(irq_flags_pkg::OFS_CONTROL, 32'h1);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h0);
      wr(irq_flags_pkg::OFS_ENABLES, 32'h81);
      abort(1'b1);
      rd_chk(irq_flags_pkg::OFS_PKT_COUNT, 32'h0);
      repeat (2) @(posedge ref_clk);
      #10 chk(32'(irq_n), 32'h0);
      pulse(5'h01);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h41);
      wr(irq_flags_pkg::OFS_ENABLES, 32'h01);
      repeat (2) @(posedge ref_clk);
      #10 chk(32'(irq_n), 32'h1);
      host_model_i.clear_flags(32'h01);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h40);
      repeat (254) pulse(5'h01);
      rd_chk(irq_flags_pkg::OFS_PKT_COUNT, 32'hff);
      abort(1'b0);
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h41);
      rd_chk(irq_flags_pkg::OFS_PKT_COUNT, 32'hff);
      // reset in mid run must drop the sticky error and the count
      rstn <= 1'b0;
      @(posedge ref_clk);
      rstn <= 1'b1;
      rd_chk(irq_flags_pkg::OFS_FLAGS, 32'h0);
      rd_chk(irq_flags_pkg::OFS_PKT_COUNT, 32'h0);
      results();
   end
endmodule // ethernet_interrupt_flags_tb
